// *** psc_defines.svh ***
// register map, field positions, reset values and timing counts of the power control block
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// register index and byte address on the bus
`define PSC_PWR_IDX 8'h87
`define PSC_PWR_ADDR {2'h0, `PSC_PWR_IDX, 2'h0}
`define PSC_ADDR_W 12

// power control fields
`define PSC_BIT_IDLE 0
`define PSC_BIT_PDOWN 1
`define PSC_BIT_GF0 2
`define PSC_BIT_GF1 3
`define PSC_BIT_BAUD 7
`define PSC_PWR_RST 8'h00

// serial port mode in which baud doubling has no effect
`define PSC_SER_MODE0 2'h0

// reset hold time: two machine cycles of twelve oscillator periods
`define PSC_RST_HOLD_OSC 24
`define PSC_CLK_PER_OSC 1
`define PSC_RST_HOLD_CYC 5'(`PSC_RST_HOLD_OSC * `PSC_CLK_PER_OSC)

// bus answer for an unmapped or reserved location
`define PSC_RD_ZERO 32'h0000_0000
`define PSC_BYTE0_HI 7

`endif

// *** psc_pkg.sv ***
// types shared by the power control block
package psc_pkg;

	// one-hot mode states
	typedef enum logic [3:0] {
		PSC_ST_RUN   = 4'h1,
		PSC_ST_IDLE  = 4'h2,
		PSC_ST_PDOWN = 4'h4,
		PSC_ST_WAKE  = 4'h8
	} psc_state_t;

	// bus strobes toward external memory
	typedef struct packed {
		logic ale;
		logic program_fetch_strobe;
	} psc_strobe_t;

	// four 8-bit ports
	typedef struct packed {
		logic [7:0] p3;
		logic [7:0] p2;
		logic [7:0] p1;
		logic [7:0] p0;
	} psc_ports_t;

	// power control register contents
	typedef struct packed {
		logic baud_double_bit;
		logic general_flag_1;
		logic general_flag_0;
		logic powerdown_bit;
		logic idle_bit;
	} psc_pwrctl_t;

endpackage

// *** psc_rst_qual.sv ***
// reset pin synchroniser and hold-time qualifier
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_rst_qual (
	// clock and block reset
	input wire logic sys_clk,
	input wire logic srst,
	// reset pin, asynchronous
	input wire logic rst_pin,
	// qualified results
	output logic pin_high,
	output logic int_rst
);

	logic sync1_r;
	logic sync2_r;
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	logic int_rst_r;
	logic int_rst_nxt;

	// count consecutive high cycles, saturate at the hold time
	always_comb begin
		cnt_nxt = 5'h00;
		if (sync2_r) begin
			if (cnt_r == `PSC_RST_HOLD_CYC) begin
				cnt_nxt = cnt_r;
			end else begin
				cnt_nxt = cnt_r + 5'h01;
			end
		end
		// reset held each cycle until the pin falls
		int_rst_nxt = sync2_r && (cnt_nxt == `PSC_RST_HOLD_CYC);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			cnt_r <= 5'h00;
			int_rst_r <= 1'b0;
		end else begin
			sync1_r <= rst_pin;
			sync2_r <= sync1_r;
			cnt_r <= cnt_nxt;
			int_rst_r <= int_rst_nxt;
		end
	end

	assign pin_high = sync2_r;
	assign int_rst = int_rst_r;

endmodule

// *** psc_avmm_slave.sv ***
// avalon-mm slave front end with one wait state
`timescale 1ns/1ps
`include "psc_defines.svh"

module psc_avmm_slave (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// avalon-mm slave
	input wire logic [`PSC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// register side
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic [7:0] reg_wdata
);

	logic wait_r;
	logic wait_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic hit;

	always_comb begin
		hit = (avs_address == `PSC_ADDR_W'(`PSC_PWR_ADDR));
		wait_nxt = 1'b1;
		rdata_nxt = rdata_r;
		// drop waitrequest for one cycle per request
		if ((avs_read || avs_write) && wait_r) begin
			wait_nxt = 1'b0;
			rdata_nxt = hit ? {24'h000000, reg_rdata} : `PSC_RD_ZERO;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wait_r <= 1'b1;
			rdata_r <= `PSC_RD_ZERO;
		end else begin
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// write commits at the edge that sees waitrequest low
	assign reg_wr = avs_write && !wait_r && hit && avs_byteenable[0];
	assign reg_wdata = avs_writedata[`PSC_BYTE0_HI:0];
	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;

endmodule

// *** psc_top.sv ***
// power saving controller: idle and power-down sequencing around the cpu core
`timescale 1ns/1ps
`include "psc_defines.svh"

// What this block does
// - an instruction setting the idle bit is the last one before idle starts
// - idle stops only the cpu clock; interrupts, timers, serial keep running
// - all cpu state is kept through idle
// - entering idle, port pins hold their levels; both strobes driven high
// - an enabled interrupt in idle clears the idle bit and wakes the cpu
// - after the interrupt return, execution resumes after the idle instruction
// - two general flag bits are readable and writable by software
// - a reset of two machine cycles, 24 oscillator periods, also ends idle
// - top register bit doubles serial baud rate in serial modes 1, 2, 3
// - writing power-down and idle together enters power-down, not idle
// - reset clears bit 7 and bits 3..0; bits 6..4 are reserved
// - an instruction setting the power-down bit is the last before power-down
// - power-down stops the oscillator, keeping ram and register contents
// - power-down drives ports from their registers and both strobes low
// - only a hardware reset leaves power-down; it reinitialises registers
// - the reset ending power-down restarts the oscillator
// - reset pin high for 24 periods; internal reset repeats while it stays high
module psc_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// avalon-mm register bus
	input wire logic [`PSC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// reset pin, asynchronous
	input wire logic rst_pin,
	// cpu core and interrupt system
	input wire logic cpu_instr_end,
	input wire logic irq_active,
	input wire logic [1:0] serial_mode,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic idle_wake,
	output logic sfr_reset,
	output logic baud_double,
	// oscillator control
	output logic osc_enable,
	// strobes and ports
	input wire psc_pkg::psc_strobe_t core_strobe,
	input wire psc_pkg::psc_ports_t core_port,
	input wire psc_pkg::psc_ports_t port_reg,
	output psc_pkg::psc_strobe_t strobe_out,
	output psc_pkg::psc_ports_t port_out
);

	logic reg_wr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic pin_high;
	logic int_rst;

	psc_pkg::psc_state_t st_r;
	psc_pkg::psc_state_t st_nxt;
	psc_pkg::psc_pwrctl_t pwr_r;
	psc_pkg::psc_pwrctl_t pwr_nxt;

	logic cpu_clk_en_r;
	logic cpu_clk_en_nxt;
	logic periph_clk_en_r;
	logic periph_clk_en_nxt;
	logic osc_enable_r;
	logic osc_enable_nxt;
	logic idle_wake_r;
	logic idle_wake_nxt;
	logic sfr_reset_r;
	logic baud_double_r;
	logic baud_double_nxt;
	psc_pkg::psc_strobe_t strobe_r;
	psc_pkg::psc_strobe_t strobe_nxt;
	psc_pkg::psc_ports_t port_r;
	psc_pkg::psc_ports_t port_nxt;

	// modes whose clocks stay alive
	function automatic logic periph_alive(input psc_pkg::psc_state_t st);
		periph_alive = (st == psc_pkg::PSC_ST_RUN) || (st == psc_pkg::PSC_ST_IDLE);
	endfunction

	psc_avmm_slave u_slave (
		.sys_clk(sys_clk),
		.srst(srst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.reg_rdata(reg_rdata),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata)
	);

	psc_rst_qual u_rst (
		.sys_clk(sys_clk),
		.srst(srst),
		.rst_pin(rst_pin),
		.pin_high(pin_high),
		.int_rst(int_rst)
	);

	// reserved bits 6..4 read as zero
	always_comb begin
		reg_rdata = `PSC_PWR_RST;
		reg_rdata[`PSC_BIT_BAUD] = pwr_r.baud_double_bit;
		reg_rdata[`PSC_BIT_GF1] = pwr_r.general_flag_1;
		reg_rdata[`PSC_BIT_GF0] = pwr_r.general_flag_0;
		reg_rdata[`PSC_BIT_PDOWN] = pwr_r.powerdown_bit;
		reg_rdata[`PSC_BIT_IDLE] = pwr_r.idle_bit;
	end

	// mode and register sequencing
	always_comb begin
		st_nxt = st_r;
		pwr_nxt = pwr_r;
		idle_wake_nxt = 1'b0;
		if (reg_wr) begin
			pwr_nxt.general_flag_1 = reg_wdata[`PSC_BIT_GF1];
			pwr_nxt.general_flag_0 = reg_wdata[`PSC_BIT_GF0];
			pwr_nxt.baud_double_bit = reg_wdata[`PSC_BIT_BAUD];
			pwr_nxt.powerdown_bit = reg_wdata[`PSC_BIT_PDOWN];
			pwr_nxt.idle_bit = reg_wdata[`PSC_BIT_IDLE];
		end
		case (st_r)
			psc_pkg::PSC_ST_RUN: begin
				// power-down begins at the end of the writing instruction
				// power-down wins when both bits are set
				if (cpu_instr_end && pwr_r.powerdown_bit) begin
					st_nxt = psc_pkg::PSC_ST_PDOWN;
				// idle begins at the end of the writing instruction
				end else if (cpu_instr_end && pwr_r.idle_bit) begin
					st_nxt = psc_pkg::PSC_ST_IDLE;
				end
			end
			psc_pkg::PSC_ST_IDLE: begin
				// enabled interrupt clears idle, software set wins
				if (irq_active && !(reg_wr && reg_wdata[`PSC_BIT_IDLE])) begin
					pwr_nxt.idle_bit = 1'b0;
					st_nxt = psc_pkg::PSC_ST_RUN;
					idle_wake_nxt = 1'b1;
				end
			end
			psc_pkg::PSC_ST_PDOWN: begin
				if (pin_high) begin
					st_nxt = psc_pkg::PSC_ST_WAKE;
				end
			end
			psc_pkg::PSC_ST_WAKE: begin
				// pulse too short to qualify: oscillator stops again
				if (!pin_high) begin
					st_nxt = psc_pkg::PSC_ST_PDOWN;
				end
			end
			default: begin
				st_nxt = psc_pkg::PSC_ST_RUN;
			end
		endcase
		// reset is the only way out of power-down
		if (int_rst) begin
			st_nxt = psc_pkg::PSC_ST_RUN;
			pwr_nxt = '0;
			idle_wake_nxt = 1'b0;
		end
	end

	// outputs derived from the next mode
	always_comb begin
		// only the cpu clock is gated in idle
		// cpu state is held because its clock stops
		cpu_clk_en_nxt = (st_nxt == psc_pkg::PSC_ST_RUN);
		periph_clk_en_nxt = periph_alive(st_nxt);
		osc_enable_nxt = (st_nxt != psc_pkg::PSC_ST_PDOWN);
		// baud doubling only outside serial mode 0
		baud_double_nxt = pwr_nxt.baud_double_bit && (serial_mode != `PSC_SER_MODE0);
		strobe_nxt = core_strobe;
		port_nxt = core_port;
		case (st_nxt)
			psc_pkg::PSC_ST_RUN: begin
				strobe_nxt = core_strobe;
				port_nxt = core_port;
			end
			psc_pkg::PSC_ST_IDLE: begin
				strobe_nxt = '{ale: 1'b1, program_fetch_strobe: 1'b1};
				port_nxt = port_r;
			end
			psc_pkg::PSC_ST_PDOWN, psc_pkg::PSC_ST_WAKE: begin
				// ports from their registers, strobes low
				strobe_nxt = '{ale: 1'b0, program_fetch_strobe: 1'b0};
				port_nxt = port_reg;
			end
			default: begin
				strobe_nxt = core_strobe;
				port_nxt = core_port;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= psc_pkg::PSC_ST_RUN;
			pwr_r <= '0;
			cpu_clk_en_r <= 1'b1;
			periph_clk_en_r <= 1'b1;
			osc_enable_r <= 1'b1;
			idle_wake_r <= 1'b0;
			sfr_reset_r <= 1'b1;
			baud_double_r <= 1'b0;
			strobe_r <= '0;
			port_r <= '0;
		end else begin
			st_r <= st_nxt;
			pwr_r <= pwr_nxt;
			cpu_clk_en_r <= cpu_clk_en_nxt;
			periph_clk_en_r <= periph_clk_en_nxt;
			osc_enable_r <= osc_enable_nxt;
			idle_wake_r <= idle_wake_nxt;
			// repeated while the pin stays high
			sfr_reset_r <= int_rst;
			baud_double_r <= baud_double_nxt;
			strobe_r <= strobe_nxt;
			port_r <= port_nxt;
		end
	end

	// cpu resumes from its held program counter once ungated
	assign cpu_clk_en = cpu_clk_en_r;
	assign periph_clk_en = periph_clk_en_r;
	assign osc_enable = osc_enable_r;
	assign idle_wake = idle_wake_r;
	assign sfr_reset = sfr_reset_r;
	assign baud_double = baud_double_r;
	assign strobe_out = strobe_r;
	assign port_out = port_r;

	AST_IDLE_ENTRY: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_RUN) && cpu_instr_end && pwr_r.idle_bit
		&& !pwr_r.powerdown_bit && !int_rst
		|=> (st_r == psc_pkg::PSC_ST_IDLE) && !cpu_clk_en)
		else $error("idle not entered after instruction end");

	AST_IDLE_CLOCKS: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_IDLE) |-> !cpu_clk_en && periph_clk_en && osc_enable)
		else $error("wrong clock gating in idle");

	AST_IDLE_PINS: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_IDLE) && $past(st_r == psc_pkg::PSC_ST_IDLE)
		|-> $stable(port_out) && strobe_out.ale && strobe_out.program_fetch_strobe)
		else $error("idle pins not held");

	AST_IDLE_WAKE: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_IDLE) && irq_active && !reg_wr && !int_rst
		|=> idle_wake && !pwr_r.idle_bit && cpu_clk_en ##1 !idle_wake)
		else $error("interrupt did not end idle");

	AST_PDOWN_PRIORITY: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_RUN) && cpu_instr_end && pwr_r.powerdown_bit && !int_rst
		|=> (st_r == psc_pkg::PSC_ST_PDOWN) && !osc_enable)
		else $error("power-down not entered");

	AST_PDOWN_PINS: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_PDOWN) |-> !strobe_out.ale && !strobe_out.program_fetch_strobe
		&& (port_out == $past(port_reg)))
		else $error("power-down pins wrong");

	AST_PDOWN_EXIT: assert property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_PDOWN) && !int_rst
		|=> (st_r == psc_pkg::PSC_ST_PDOWN) || (st_r == psc_pkg::PSC_ST_WAKE))
		else $error("power-down left without reset");

	AST_RST_CLEARS: assert property (@(posedge sys_clk) disable iff (srst)
		int_rst |=> (st_r == psc_pkg::PSC_ST_RUN) && (reg_rdata == `PSC_PWR_RST)
		&& sfr_reset && osc_enable)
		else $error("reset did not clear the mode");

	AST_BAUD: assert property (@(posedge sys_clk) disable iff (srst)
		##1 baud_double == ($past(pwr_nxt.baud_double_bit)
		&& ($past(serial_mode) != `PSC_SER_MODE0)))
		else $error("baud doubling mismatch");

	COV_IDLE_WAKE: cover property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_IDLE) ##1 idle_wake);
	COV_PD_RESET: cover property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_WAKE) ##1 sfr_reset);
	COV_IDLE_RESET: cover property (@(posedge sys_clk) disable iff (srst)
		(st_r == psc_pkg::PSC_ST_IDLE) && int_rst);

endmodule

// *** psc_cpu_model.sv ***
// cpu core, interrupt source and reset pin source facing the power control block
`timescale 1ns/1ps

module psc_cpu_model #(
	parameter int HOLD_LEN = 24,
	parameter int PD_LEN = 60,
	parameter int POR_LEN = 40
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// from the block
	input wire logic cpu_clk_en,
	input wire logic osc_enable,
	// bench commands
	input wire logic irq_req,
	input wire logic rst_req,
	// toward the block
	output logic cpu_instr_end,
	output logic irq_active,
	output logic rst_pin,
	output psc_pkg::psc_strobe_t core_strobe,
	output psc_pkg::psc_ports_t core_port,
	output psc_pkg::psc_ports_t port_reg
);
	logic [1:0] phase_r;
	logic [7:0] tick_r;
	int hold_r;

	// core only advances on its gated clock
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase_r <= 2'h0;
			tick_r <= 8'h00;
		end else if (cpu_clk_en) begin
			phase_r <= phase_r + 2'h1;
			tick_r <= tick_r + 8'h01;
		end
	end
	assign cpu_instr_end = cpu_clk_en && (phase_r == 2'h3);
	// strobes and ports move on each cycle with the cpu clock enabled and stop while it is gated
	assign core_strobe = {phase_r[1], phase_r[0]};
	assign core_port = {4{tick_r}};
	assign port_reg = 32'hC3A5_5A3C;
	assign irq_active = irq_req;

	always_ff @(posedge sys_clk) begin
		if (srst)
			hold_r <= POR_LEN;
		else if (rst_req)
			hold_r <= osc_enable ? HOLD_LEN : PD_LEN;
		else if (hold_r > 0)
			hold_r <= hold_r - 1;
	end
	assign rst_pin = (hold_r > 0);
endmodule

// *** tb_power_saving_control.sv ***
// self-checking bench for the power control block
`timescale 1ns/1ps
`include "psc_defines.svh"

module tb_power_saving_control;
	typedef struct {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic [3:0] be;
		logic [1:0] mode;
		logic [7:0] exp_rd;
		logic exp_baud;
	} psc_row_t;

	logic sys_clk, srst, avs_read, avs_write, avs_waitrequest, rst_pin, cpu_instr_end;
	logic irq_active, cpu_clk_en, periph_clk_en, idle_wake, sfr_reset, baud_double;
	logic osc_enable, irq_req, rst_req;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, snap;
	logic [3:0] avs_byteenable;
	logic [1:0] serial_mode;
	psc_pkg::psc_strobe_t core_strobe, strobe_out;
	psc_pkg::psc_ports_t core_port, port_reg, port_out;
	psc_row_t rows [7];
	int fail_count, compares;

	psc_top dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rst_pin(rst_pin), .cpu_instr_end(cpu_instr_end),
		.irq_active(irq_active), .serial_mode(serial_mode), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .idle_wake(idle_wake), .sfr_reset(sfr_reset),
		.baud_double(baud_double), .osc_enable(osc_enable), .core_strobe(core_strobe),
		.core_port(core_port), .port_reg(port_reg), .strobe_out(strobe_out),
		.port_out(port_out));

	psc_cpu_model cpu (.sys_clk(sys_clk), .srst(srst), .cpu_clk_en(cpu_clk_en),
		.osc_enable(osc_enable), .irq_req(irq_req), .rst_req(rst_req),
		.cpu_instr_end(cpu_instr_end), .irq_active(irq_active), .rst_pin(rst_pin),
		.core_strobe(core_strobe), .core_port(core_port), .port_reg(port_reg));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic close_out();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: flag %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	// one avalon transfer, held until waitrequest is seen low
	task automatic bus_cyc(input logic wr, input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		chk_bit(avs_waitrequest, 1'b0);
		if (avs_waitrequest !== 1'b0)
			close_out();
	endtask

	// bounded wait for a block output or the reset pin to reach a level
	task automatic wait_sig(input int sel, input logic val);
		int n;
		logic s;
		n = 0;
		do begin
			@(posedge sys_clk);
			case (sel)
				0: s = cpu_clk_en;
				1: s = osc_enable;
				2: s = idle_wake;
				3: s = sfr_reset;
				default: s = rst_pin;
			endcase
			n++;
		end while (s !== val && n < 400);
		if (s !== val) begin
			$display("CHECK FAILED at %0t: wait saw %h wanted %h", $time, s, val);
			fail_count++;
			close_out();
		end
	endtask

	task automatic pulse_rst();
		@(posedge sys_clk);
		rst_req <= 1'b1;
		@(posedge sys_clk);
		rst_req <= 1'b0;
	endtask

	initial begin
		fail_count = 0;
		compares = 0;
		srst = 1'b1;
		avs_address = 12'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		serial_mode = 2'h0;
		irq_req = 1'b0;
		rst_req = 1'b0;
		rows[0] = '{`PSC_PWR_ADDR, 8'h80, 4'h1, 2'h1, 8'h80, 1'b1};
		rows[1] = '{`PSC_PWR_ADDR, 8'h80, 4'h1, 2'h0, 8'h80, 1'b0};
		rows[2] = '{`PSC_PWR_ADDR, 8'h80, 4'h1, 2'h3, 8'h80, 1'b1};
		rows[3] = '{`PSC_PWR_ADDR, 8'h0C, 4'h1, 2'h2, 8'h0C, 1'b0};
		rows[4] = '{`PSC_PWR_ADDR, 8'hF4, 4'h1, 2'h2, 8'h84, 1'b1};
		rows[5] = '{`PSC_PWR_ADDR, 8'h08, 4'h0, 2'h1, 8'h84, 1'b1};
		rows[6] = '{12'h220, 8'hFF, 4'h1, 2'h1, 8'h00, 1'b1};
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		// power-on pin hold from the partner must run out first
		wait_sig(4, 1'b0);
		wait_sig(3, 1'b0);
		bus_cyc(1'b0, `PSC_PWR_ADDR, 8'h00, 4'h1, rd);
		chk32(rd, 32'h0000_0000);
		chk_bit(cpu_clk_en, 1'b1);
		chk_bit(baud_double, 1'b0);
		for (int i = 0; i < 7; i++) begin
			serial_mode <= rows[i].mode;
			bus_cyc(1'b1, rows[i].addr, rows[i].wdata, rows[i].be, rd);
			bus_cyc(1'b0, rows[i].addr, 8'h00, 4'h1, rd);
			chk32(rd, {24'h00_0000, rows[i].exp_rd});
			chk_bit(baud_double, rows[i].exp_baud);
		end
		// idle entry with a flag set in the same write, then interrupt wake
		bus_cyc(1'b1, `PSC_PWR_ADDR, 8'h05, 4'h1, rd);
		wait_sig(0, 1'b0);
		chk_bit(periph_clk_en, 1'b1);
		chk_bit(osc_enable, 1'b1);
		@(posedge sys_clk);
		snap = port_out;
		chk32({30'h0, strobe_out}, 32'h0000_0003);
		repeat (8) @(posedge sys_clk);
		chk32(port_out, snap);
		bus_cyc(1'b0, `PSC_PWR_ADDR, 8'h00, 4'h1, rd);
		chk32(rd, 32'h0000_0005);
		irq_req <= 1'b1;
		wait_sig(2, 1'b1);
		irq_req <= 1'b0;
		chk_bit(cpu_clk_en, 1'b1);
		bus_cyc(1'b0, `PSC_PWR_ADDR, 8'h00, 4'h1, rd);
		chk32(rd, 32'h0000_0004);
		// both mode bits together: power-down wins, only the pin ends it
		bus_cyc(1'b1, `PSC_PWR_ADDR, 8'h03, 4'h1, rd);
		wait_sig(1, 1'b0);
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk32({30'h0, strobe_out}, 32'h0000_0000);
		chk32(port_out, 32'hC3A5_5A3C);
		chk_bit(cpu_clk_en, 1'b0);
		chk_bit(periph_clk_en, 1'b0);
		irq_req <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk_bit(osc_enable, 1'b0);
		bus_cyc(1'b0, `PSC_PWR_ADDR, 8'h00, 4'h1, rd);
		chk32(rd, 32'h0000_0003);
		irq_req <= 1'b0;
		pulse_rst();
		wait_sig(1, 1'b1);
		wait_sig(3, 1'b1);
		wait_sig(3, 1'b0);
		bus_cyc(1'b0, `PSC_PWR_ADDR, 8'h00, 4'h1, rd);
		chk32(rd, 32'h0000_0000);
		chk_bit(cpu_clk_en, 1'b1);
		// shortest legal pin reset ends idle
		bus_cyc(1'b1, `PSC_PWR_ADDR, 8'h01, 4'h1, rd);
		wait_sig(0, 1'b0);
		pulse_rst();
		wait_sig(3, 1'b1);
		wait_sig(3, 1'b0);
		wait_sig(0, 1'b1);
		bus_cyc(1'b0, `PSC_PWR_ADDR, 8'h00, 4'h1, rd);
		chk32(rd, 32'h0000_0000);
		close_out();
	end
endmodule
